/* File: pkg/dmx_pkg.sv */
// constants and types shared by the data-move execution block
package dmx_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_INSTR  = 8'h04;
	localparam logic [7:0] REG_ACC    = 8'h08;
	localparam logic [7:0] REG_BANK   = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_EXT_BIT    = 0;
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_NEG_BIT    = 1;
	localparam int STAT_ZERO_BIT   = 2;
	localparam int STAT_WAIT_BIT   = 3;
	localparam int STAT_IDX_BIT    = 4;
	localparam int STAT_BADDST_BIT = 5;
	localparam int STAT_SEQERR_BIT = 6;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ACC_RST  = 8'h00;
	localparam logic [3:0] BANK_RST = 4'h0;
	localparam logic       EXT_RST  = 1'b0;

	// ----------------------------------------------------------------
	// opcode patterns and addressing constants
	// ----------------------------------------------------------------
	localparam logic [5:0] OP_COPY_REG  = 6'h14;
	localparam logic [3:0] OP_F2F_SRC   = 4'hc;
	localparam logic [3:0] OP_F2F_DST   = 4'hf;
	localparam logic [7:0] OP_LOAD_BANK = 8'h01;
	localparam logic [7:0] OP_LOAD_ACC  = 8'h0e;
	localparam logic [7:0] IDX_LIMIT    = 8'h5f;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] PAGE_LOW     = 4'h0;
	localparam logic [3:0] PAGE_HIGH    = 4'hf;

	// ----------------------------------------------------------------
	// quarter phases of one instruction cycle, bus answers
	// ----------------------------------------------------------------
	localparam logic [1:0] Q1 = 2'h0;
	localparam logic [1:0] Q2 = 2'h1;
	localparam logic [1:0] Q3 = 2'h2;
	localparam logic [1:0] Q4 = 2'h3;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WAIT2, ST_EXEC2} dmx_state_e;

	typedef enum logic [2:0] {
		K_NONE, K_COPY_REG, K_F2F_SRC, K_F2F_DST, K_LOAD_BANK, K_LOAD_ACC
	} dmx_kind_e;

endpackage

/* File: sim/dmx_exec_tb.sv */
// self-checking bench for the data-move executor
`timescale 1ns/1ns
module dmx_exec_tb;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  awAddr = 8'h00;
	logic        awValid = 1'b0;
	logic        awReady;
	logic [31:0] wData = 32'h0;
	logic        wValid = 1'b0;
	logic        wReady;
	logic [1:0]  bResp;
	logic        bValid;
	logic        bReady = 1'b0;
	logic [7:0]  arAddr = 8'h00;
	logic        arValid = 1'b0;
	logic        arReady;
	logic [31:0] rData;
	logic [1:0]  rResp;
	logic        rValid;
	logic        rReady = 1'b0;
	logic [11:0] mAddr;
	logic        mRd;
	logic        mWr;
	logic [7:0]  mWdata;
	logic        mIdx;
	logic [7:0]  mRdata = 8'h00;
	logic [7:0]  bankPtr;
	logic [7:0]  mem [4096];
	logic [11:0] rdAddr = 12'h0;
	logic [11:0] wrAddr = 12'h0;
	int          rdCnt = 0;
	int          wrCnt = 0;
	int          idxCnt = 0;
	int          bad_count = 0;
	int          n_compared = 0;

	always #50 clock = ~clock;

	dmx_exec dut
	(
		.clock(clock), .rst_n(rst_n),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp),
		.s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
		.s_axi_arready(arReady), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .s_axi_rvalid(rValid),
		.s_axi_rready(rReady), .dmemAddr(mAddr), .dmemRd(mRd),
		.dmemWr(mWr), .dmemWdata(mWdata), .dmemIdx(mIdx),
		.dmemRdata(mRdata), .bankPointer(bankPtr)
	);

	// ----------------------------------------------------------------
	// data space model, data invalid outside the read slot
	// ----------------------------------------------------------------
	always @(posedge clock)
	begin
		mRdata <= mRd ? mem[mAddr] : ~mRdata;
		if (mRd)
		begin
			rdAddr <= mAddr;
			rdCnt <= rdCnt + 1;
		end
		if (mWr)
		begin
			mem[mAddr] <= mWdata;
			wrAddr <= mAddr;
			wrCnt <= wrCnt + 1;
		end
		if (mIdx)
			idxCnt <= idxCnt + 1;
	end

	// ----------------------------------------------------------------
	// compare, bus and execution tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			bad_count++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic chkr(input logic [1:0] g, input logic [1:0] e);
		chk({30'h0, g}, {30'h0, e});
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		bit ta;
		bit tw;
		ta = 0;
		tw = 0;
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		while (!(ta && tw))
		begin
			@(posedge clock);
			if (!ta && awReady === 1'b1)
			begin
				ta = 1;
				awValid <= 1'b0;
			end
			if (!tw && wReady === 1'b1)
			begin
				tw = 1;
				wValid <= 1'b0;
			end
		end
		do @(posedge clock); while (bValid !== 1'b1);
		r = bResp;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		do @(posedge clock); while (arReady !== 1'b1);
		arValid <= 1'b0;
		do @(posedge clock); while (rValid !== 1'b1);
		d = rData;
		r = rResp;
	endtask

	task automatic rdv(input logic [7:0] a, output logic [31:0] d);
		logic [1:0] r;
		rd(a, d, r);
	endtask

	task automatic exec(input logic [15:0] ins);
		logic [1:0]  r;
		logic [31:0] s;
		wr(dmx_pkg::REG_INSTR, {16'h0, ins}, r);
		chkr(r, dmx_pkg::RESP_OKAY);
		do rdv(dmx_pkg::REG_STATUS, s); while (s[0] !== 1'b0);
	endtask

	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	function automatic logic [11:0] eAddr(input logic a,
		input logic [7:0] f, input logic [3:0] bank);
		if (a)
			return {bank, f};
		return {(f < dmx_pkg::ACCESS_SPLIT) ? 4'h0 : 4'hf, f};
	endfunction

	function automatic logic [31:0] flg(input logic [7:0] v);
		return {29'h0, v == 8'h00, v[7], 1'b0};
	endfunction

	initial
	begin
		#(100 * 30000);
		bad_count++;
		end_sim();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic [31:0] d;
		logic [31:0] fl;
		logic [1:0]  r;
		logic [7:0]  k;
		logic [7:0]  f;
		logic [7:0]  v;
		logic [11:0] ea;
		logic [11:0] sa;
		logic [11:0] da;
		int          n;
		void'($urandom(32'h48d0));
		foreach (mem[i])
			mem[i] = $urandom;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		rdv(dmx_pkg::REG_ACC, d);
		chk(d, 32'h0);
		fl = 32'h0;
		for (int i = 0; i < 8; i++)
		begin
			k = (i == 0) ? 8'hff : $urandom;
			exec({dmx_pkg::OP_LOAD_BANK, k});
			rdv(dmx_pkg::REG_BANK, d);
			chk(d, {28'h0, k[3:0]});
			chk({24'h0, bankPtr}, {28'h0, k[3:0]});
			exec({dmx_pkg::OP_LOAD_ACC, ~k});
			rdv(dmx_pkg::REG_ACC, d);
			chk(d, {24'h0, ~k});
			rdv(dmx_pkg::REG_STATUS, d);
			chk(d & 32'h6, fl);
			f = $urandom % 8'hf0;
			v = (i == 1) ? 8'h00 : (i == 2) ? 8'h80 : $urandom;
			ea = eAddr(i[0], f, k[3:0]);
			mem[ea] = v;
			exec({dmx_pkg::OP_COPY_REG, 1'b0, i[0], f});
			rdv(dmx_pkg::REG_ACC, d);
			chk(d, {24'h0, v});
			chk({20'h0, rdAddr}, {20'h0, ea});
			rdv(dmx_pkg::REG_STATUS, d);
			chk(d & 32'h6, flg(v));
			n = wrCnt;
			exec({dmx_pkg::OP_COPY_REG, 1'b1, i[0], f});
			chk(wrCnt, n + 1);
			chk({20'h0, wrAddr}, {20'h0, ea});
			chk({24'h0, mem[ea]}, {24'h0, v});
			rdv(dmx_pkg::REG_STATUS, d);
			chk(d & 32'h6, flg(v));
			fl = flg(v);
		end
		for (int j = 0; j < 3; j++)
		begin
			f = (j == 1) ? 8'h60 : dmx_pkg::IDX_LIMIT;
			wr(dmx_pkg::REG_CTRL, {31'h0, j != 2}, r);
			n = idxCnt;
			exec({dmx_pkg::OP_COPY_REG, 2'b00, f});
			chk(idxCnt - n, (j == 0) ? 1 : 0);
		end
		fl = flg(mem[12'h05f]);
		rdv(dmx_pkg::REG_STATUS, d);
		chk(d & 32'h6, fl);
		repeat (4)
		begin
			sa = $urandom % 12'h800;
			da = 12'h800 + $urandom % 12'h7f0;
			v = $urandom;
			mem[sa] = v;
			exec({dmx_pkg::OP_F2F_SRC, sa});
			rdv(dmx_pkg::REG_STATUS, d);
			chk({31'h0, d[3]}, 32'h1);
			n = rdCnt;
			exec({dmx_pkg::OP_F2F_DST, da});
			chk(rdCnt, n);
			chk({24'h0, mem[da]}, {24'h0, v});
			chk({20'h0, wrAddr}, {20'h0, da});
			rdv(dmx_pkg::REG_STATUS, d);
			chk(d & 32'h6, fl);
		end
		k = $urandom;
		exec({dmx_pkg::OP_LOAD_ACC, k});
		exec({dmx_pkg::OP_F2F_SRC, 12'hff8});
		exec({dmx_pkg::OP_F2F_DST, 12'h321});
		chk({24'h0, mem[12'h321]}, {24'h0, k});
		mem[12'h123] = ~k;
		exec({dmx_pkg::OP_F2F_SRC, 12'h123});
		exec({dmx_pkg::OP_F2F_DST, 12'hff8});
		rdv(dmx_pkg::REG_ACC, d);
		chk(d, {24'h0, ~k});
		for (int j = 0; j < 4; j++)
		begin
			n = wrCnt;
			exec({dmx_pkg::OP_F2F_SRC, 12'h010});
			exec({dmx_pkg::OP_F2F_DST, 12'hff0 + j[11:0]});
			chk(wrCnt, n);
			rdv(dmx_pkg::REG_STATUS, d);
			chk({31'h0, d[5]}, 32'h1);
			wr(dmx_pkg::REG_STATUS, 32'h20, r);
			rdv(dmx_pkg::REG_STATUS, d);
			chk({31'h0, d[5]}, 32'h0);
		end
		exec({dmx_pkg::OP_F2F_SRC, 12'h010});
		wr(dmx_pkg::REG_ACC, {24'h0, v}, r);
		chkr(r, dmx_pkg::RESP_OKAY);
		n = wrCnt;
		exec({dmx_pkg::OP_LOAD_ACC, ~v});
		chk(wrCnt, n);
		rdv(dmx_pkg::REG_ACC, d);
		chk(d, {24'h0, v});
		rdv(dmx_pkg::REG_STATUS, d);
		chk(d & 32'h48, 32'h40);
		wr(dmx_pkg::REG_STATUS, 32'h40, r);
		rdv(dmx_pkg::REG_STATUS, d);
		chk(d & 32'h40, 32'h0);
		rd(8'h14, d, r);
		chkr(r, dmx_pkg::RESP_SLVERR);
		chk(d, 32'h0);
		wr(dmx_pkg::REG_BANK, 32'h5, r);
		chkr(r, dmx_pkg::RESP_SLVERR);
		end_sim();
	end
endmodule

/* File: verilog/dmx_decode.sv */
// opcode and operand decoder for the four data-move instructions
`timescale 1ns/1ns
module dmx_decode
(
	input  wire logic [15:0]    word,
	output dmx_pkg::dmx_kind_e  kind,
	output logic                dirBit,
	output logic                accessBit,
	output logic [7:0]          lowByte,
	output logic [11:0]         addr12
);

	// ----------------------------------------------------------------
	// pattern match on the upper opcode bits
	// ----------------------------------------------------------------
	always_comb
	begin
		if (word[15:10] == dmx_pkg::OP_COPY_REG)
			kind = dmx_pkg::K_COPY_REG;
		else if (word[15:12] == dmx_pkg::OP_F2F_SRC)
			kind = dmx_pkg::K_F2F_SRC;
		else if (word[15:12] == dmx_pkg::OP_F2F_DST)
			kind = dmx_pkg::K_F2F_DST;
		else if (word[15:8] == dmx_pkg::OP_LOAD_BANK)
			kind = dmx_pkg::K_LOAD_BANK;
		else if (word[15:8] == dmx_pkg::OP_LOAD_ACC)
			kind = dmx_pkg::K_LOAD_ACC;
		else
			kind = dmx_pkg::K_NONE;
	end

	assign dirBit    = word[9];
	assign accessBit = word[8];
	assign lowByte   = word[7:0];
	assign addr12    = word[11:0];

endmodule

/* File: verilog/dmx_exec.sv */
// data-move instruction executor with axi4-lite register access
`timescale 1ns/1ns
// Overview of operation
// [RQ1] copy_register is 0101 00, then direction bit, access bit, 8-bit address.
// [RQ2] direction clear: value goes to accumulator, negative and zero updated.
// [RQ3] direction set: value written back to same register, flags updated.
// [RQ4] the 8-bit address reaches any location of the selected bank.
// [RQ5] access bit clear uses access bank; set uses bank_pointer as page.
// [RQ6] extended set, access clear, address up to 5Fh: indexed offset.
// [RQ7] copy_file_to_file: word 1100 source, word 1111 destination, value moved.
// [RQ8] both addresses span 000h to FFFh, bank_pointer unused.
// [RQ9] accumulator reachable by its data address as source or destination.
// [RQ10] programs never target counter low byte or stack-top bytes.
// [RQ11] load_bank_literal takes the low nibble, upper nibble forced zero.
// [RQ12] load_accumulator_literal puts the literal into the accumulator.
// [RQ13] only copy_register changes flags; file move takes two cycles.
// [RQ14] second file-move cycle: no data read, write in last quarter.
module dmx_exec
#(
	parameter int          ADDR_W    = 8,
	parameter logic [11:0] ACC_ADDR  = 12'hff8,
	parameter logic [11:0] PCL_ADDR  = 12'hff0,
	parameter logic [11:0] STACK_TOP_LOW_BYTE_ADDR = 12'hff1,
	parameter logic [11:0] STACK_TOP_HIGH_BYTE_ADDR = 12'hff2,
	parameter logic [11:0] STACK_TOP_UPPER_BYTE_ADDR = 12'hff3
)
(
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [11:0]            dmemAddr,
	output logic                   dmemRd,
	output logic                   dmemWr,
	output logic [7:0]             dmemWdata,
	output logic                   dmemIdx,
	input  wire logic [7:0]        dmemRdata,
	output logic [7:0]             bankPointer
);

	typedef struct packed
	{
		dmx_pkg::dmx_state_e st;
		logic [15:0]         instr;
		logic [7:0]          acc;
		logic [3:0]          bank;
		logic                neg;
		logic                zero;
		logic                extEn;
		logic [7:0]          data;
		logic                idxLast;
		logic                badDest;
		logic                seqErr;
		logic                awTaken;
		logic [ADDR_W-1:0]   awAddr;
		logic                wTaken;
		logic [31:0]         wData;
		logic [3:0]          wStrb;
		logic                awready;
		logic                wready;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                arready;
		logic                rvalid;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
		logic [11:0]         memAddr;
		logic                memRd;
		logic                memWr;
		logic [7:0]          memWdata;
		logic                memIdx;
	} dmx_core_s;

	dmx_core_s          r;
	dmx_core_s          n;
	logic [1:0]         q;
	dmx_pkg::dmx_kind_e kind;
	logic               dirBit;
	logic               accessBit;
	logic [7:0]         lowByte;
	logic [11:0]        addr12;
	logic               busy;
	logic               copyIdx;
	logic [11:0]        copyAddr;
	logic               copyAcc;
	logic               f2fSrcAcc;
	logic               f2fDstAcc;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] byteLane(input logic [7:0] old,
		input logic [7:0] upd, input logic en);
		byteLane = en ? upd : old;
	endfunction

	function automatic logic forbiddenDst(input logic [11:0] a);
		forbiddenDst = (a == PCL_ADDR) || (a == STACK_TOP_LOW_BYTE_ADDR) ||
			(a == STACK_TOP_HIGH_BYTE_ADDR) || (a == STACK_TOP_UPPER_BYTE_ADDR);
	endfunction

	// ----------------------------------------------------------------
	// submodules
	// ----------------------------------------------------------------
	dmx_qphase u_qphase
	(
		.clock (clock),
		.rst_n (rst_n),
		.run   (busy),
		.phase (q)
	);

	dmx_decode u_decode
	(
		.word      (r.instr),
		.kind      (kind),
		.dirBit    (dirBit),
		.accessBit (accessBit),
		.lowByte   (lowByte),
		.addr12    (addr12)
	);

	// ----------------------------------------------------------------
	// operand addressing
	// ----------------------------------------------------------------
	assign busy = (r.st == dmx_pkg::ST_EXEC) || (r.st == dmx_pkg::ST_EXEC2);
	assign copyIdx = r.extEn && !accessBit &&
		(lowByte <= dmx_pkg::IDX_LIMIT);                              // [RQ6]

	always_comb
	begin
		if (accessBit)
			copyAddr = {r.bank, lowByte};                             // [RQ5]
		else if (lowByte < dmx_pkg::ACCESS_SPLIT)
			copyAddr = {dmx_pkg::PAGE_LOW, lowByte};                  // [RQ4]
		else
			copyAddr = {dmx_pkg::PAGE_HIGH, lowByte};
	end

	assign copyAcc   = !copyIdx && (copyAddr == ACC_ADDR);
	assign f2fSrcAcc = (addr12 == ACC_ADDR);                            // [RQ9]
	assign f2fDstAcc = (addr12 == ACC_ADDR);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		n = r;
		n.memRd = 1'b0;
		n.memWr = 1'b0;
		n.memIdx = 1'b0;

		// bus write: collect address and data in either order
		if (s_axi_awvalid && r.awready)
		begin
			n.awTaken = 1'b1;
			n.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && r.wready)
		begin
			n.wTaken = 1'b1;
			n.wData = s_axi_wdata;
			n.wStrb = s_axi_wstrb;
		end
		if (r.bvalid && s_axi_bready)
			n.bvalid = 1'b0;
		if (r.awTaken && r.wTaken && !r.bvalid)
		begin
			n.awTaken = 1'b0;
			n.wTaken = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = dmx_pkg::RESP_OKAY;
			case (r.awAddr)
				dmx_pkg::REG_CTRL:
					if (r.wStrb[0])
						n.extEn = r.wData[dmx_pkg::CTRL_EXT_BIT];
				dmx_pkg::REG_INSTR:
					if (busy)
						n.bresp = dmx_pkg::RESP_SLVERR;
					else
					begin
						n.instr[7:0] = byteLane(r.instr[7:0],
							r.wData[7:0], r.wStrb[0]);
						n.instr[15:8] = byteLane(r.instr[15:8],
							r.wData[15:8], r.wStrb[1]);
						if (r.st == dmx_pkg::ST_WAIT2)
							n.st = dmx_pkg::ST_EXEC2;
						else
							n.st = dmx_pkg::ST_EXEC;
					end
				dmx_pkg::REG_ACC:
					if (busy)
						n.bresp = dmx_pkg::RESP_SLVERR;
					else
						n.acc = byteLane(r.acc, r.wData[7:0], r.wStrb[0]);
				dmx_pkg::REG_STATUS:
					if (r.wStrb[0])
					begin
						if (r.wData[dmx_pkg::STAT_BADDST_BIT])
							n.badDest = 1'b0;
						if (r.wData[dmx_pkg::STAT_SEQERR_BIT])
							n.seqErr = 1'b0;
					end
				default:
					n.bresp = dmx_pkg::RESP_SLVERR;
			endcase
		end

		// bus read
		if (r.rvalid && s_axi_rready)
			n.rvalid = 1'b0;
		if (s_axi_arvalid && r.arready)
		begin
			n.rvalid = 1'b1;
			n.rresp = dmx_pkg::RESP_OKAY;
			n.rdata = '0;
			case (s_axi_araddr)
				dmx_pkg::REG_CTRL:
					n.rdata[dmx_pkg::CTRL_EXT_BIT] = r.extEn;
				dmx_pkg::REG_INSTR:
					n.rdata[15:0] = r.instr;
				dmx_pkg::REG_ACC:
					n.rdata[7:0] = r.acc;
				dmx_pkg::REG_BANK:
					n.rdata[3:0] = r.bank;
				dmx_pkg::REG_STATUS:
				begin
					n.rdata[dmx_pkg::STAT_BUSY_BIT] = busy;
					n.rdata[dmx_pkg::STAT_NEG_BIT] = r.neg;
					n.rdata[dmx_pkg::STAT_ZERO_BIT] = r.zero;
					n.rdata[dmx_pkg::STAT_WAIT_BIT] =
						(r.st == dmx_pkg::ST_WAIT2);
					n.rdata[dmx_pkg::STAT_IDX_BIT] = r.idxLast;
					n.rdata[dmx_pkg::STAT_BADDST_BIT] = r.badDest;
					n.rdata[dmx_pkg::STAT_SEQERR_BIT] = r.seqErr;
				end
				default:
					n.rresp = dmx_pkg::RESP_SLVERR;
			endcase
		end

		// execution; error sets come after the clears so they win
		case (r.st)
			dmx_pkg::ST_EXEC:
				case (q)
					dmx_pkg::Q1:
						if (kind == dmx_pkg::K_COPY_REG)
						begin
							n.memRd = !copyAcc;                       // [RQ1]
							n.memAddr = copyIdx ? {dmx_pkg::PAGE_LOW,
								lowByte} : copyAddr;                  // [RQ4]
							n.memIdx = copyIdx;                       // [RQ6]
							n.idxLast = copyIdx;
						end
						else if (kind == dmx_pkg::K_F2F_SRC)
						begin
							n.memRd = !f2fSrcAcc;                     // [RQ9]
							n.memAddr = addr12;                       // [RQ8]
							n.idxLast = 1'b0;
						end
					dmx_pkg::Q3:
						if (kind == dmx_pkg::K_COPY_REG ||
							kind == dmx_pkg::K_F2F_SRC)
						begin
							if ((kind == dmx_pkg::K_COPY_REG && copyAcc) ||
								(kind == dmx_pkg::K_F2F_SRC && f2fSrcAcc))
								n.data = r.acc;
							else
								n.data = dmemRdata;
							if (kind == dmx_pkg::K_COPY_REG && dirBit &&
								!copyAcc)
							begin
								n.memWr = 1'b1;                       // [RQ3]
								n.memWdata = dmemRdata;
								n.memIdx = copyIdx;
							end
						end
					dmx_pkg::Q4:
					begin
						n.st = dmx_pkg::ST_IDLE;                      // [RQ13]
						case (kind)
							dmx_pkg::K_COPY_REG:
							begin
								if (!dirBit)
									n.acc = r.data;                   // [RQ2]
								n.neg = r.data[7];                    // [RQ2]
								n.zero = (r.data == 8'h00);
							end
							dmx_pkg::K_F2F_SRC:
								n.st = dmx_pkg::ST_WAIT2;             // [RQ7]
							dmx_pkg::K_LOAD_BANK:
								n.bank = lowByte[3:0];                // [RQ11]
							dmx_pkg::K_LOAD_ACC:
								n.acc = lowByte;                      // [RQ12]
							default:
								n.st = dmx_pkg::ST_IDLE;
						endcase
					end
					default:
						n.st = r.st;
				endcase
			dmx_pkg::ST_EXEC2:
				case (q)
					dmx_pkg::Q3:
						if (kind != dmx_pkg::K_F2F_DST)
							n.seqErr = 1'b1;
						else if (forbiddenDst(addr12))
							n.badDest = 1'b1;                         // [RQ10]
						else if (!f2fDstAcc)
						begin
							n.memWr = 1'b1;                           // [RQ14]
							n.memAddr = addr12;                       // [RQ8]
							n.memWdata = r.data;                      // [RQ7]
						end
					dmx_pkg::Q4:
					begin
						if (kind == dmx_pkg::K_F2F_DST && f2fDstAcc)
							n.acc = r.data;                           // [RQ9]
						n.st = dmx_pkg::ST_IDLE;
					end
					default:
						n.st = r.st;
				endcase
			default:
				n.st = n.st;
		endcase

		n.awready = !n.awTaken && !n.bvalid;
		n.wready = !n.wTaken && !n.bvalid;
		n.arready = !n.rvalid;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r <= '0;
			r.acc <= dmx_pkg::ACC_RST;
			r.bank <= dmx_pkg::BANK_RST;
			r.extEn <= dmx_pkg::EXT_RST;
		end
		else
			r <= n;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign s_axi_awready = r.awready;
	assign s_axi_wready  = r.wready;
	assign s_axi_bvalid  = r.bvalid;
	assign s_axi_bresp   = r.bresp;
	assign s_axi_arready = r.arready;
	assign s_axi_rvalid  = r.rvalid;
	assign s_axi_rdata   = r.rdata;
	assign s_axi_rresp   = r.rresp;
	assign dmemAddr      = r.memAddr;
	assign dmemRd        = r.memRd;
	assign dmemWr        = r.memWr;
	assign dmemWdata     = r.memWdata;
	assign dmemIdx       = r.memIdx;
	assign bankPointer   = {4'h0, r.bank};                              // [RQ11]

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	a_copy_read: assert property (                                  // [RQ1]
		r.st == dmx_pkg::ST_EXEC && q == dmx_pkg::Q1 &&
		kind == dmx_pkg::K_COPY_REG && !copyAcc
		|=> r.memRd && r.memAddr[7:0] == $past(lowByte))
		else $error("copy_register did not read its address");

	a_copy_acc: assert property (                                   // [RQ2]
		r.st == dmx_pkg::ST_EXEC && q == dmx_pkg::Q4 &&
		kind == dmx_pkg::K_COPY_REG && !dirBit
		|=> r.acc == $past(r.data) && r.neg == $past(r.data[7]) &&
		r.zero == ($past(r.data) == 8'h00))
		else $error("copy_register to accumulator wrong");

	a_copy_back: assert property (                                  // [RQ3]
		r.st == dmx_pkg::ST_EXEC && q == dmx_pkg::Q3 &&
		kind == dmx_pkg::K_COPY_REG && dirBit && !copyAcc
		|=> r.memWr && r.memWdata == $past(dmemRdata) &&
		$stable(r.memAddr))
		else $error("copy_register write-back wrong");

	a_bank_page: assert property (                                  // [RQ5]
		r.st == dmx_pkg::ST_EXEC && q == dmx_pkg::Q1 &&
		kind == dmx_pkg::K_COPY_REG && accessBit && !copyAcc
		|=> r.memAddr == {r.bank, $past(lowByte)})
		else $error("bank pointer page not used");

	a_indexed_mode: assert property (                               // [RQ6]
		r.st == dmx_pkg::ST_EXEC && q == dmx_pkg::Q1 &&
		kind == dmx_pkg::K_COPY_REG && r.extEn && !accessBit &&
		lowByte <= dmx_pkg::IDX_LIMIT
		|=> r.memIdx && r.memRd)
		else $error("indexed offset not flagged");

	a_f2f_write: assert property (                                  // [RQ7]
		r.st == dmx_pkg::ST_EXEC2 && q == dmx_pkg::Q3 &&
		kind == dmx_pkg::K_F2F_DST && !f2fDstAcc && !forbiddenDst(addr12)
		|=> r.memWr && r.memAddr == $past(addr12) &&
		r.memWdata == $past(r.data))
		else $error("file move destination write wrong");

	a_bank_load: assert property (                                  // [RQ11]
		r.st == dmx_pkg::ST_EXEC && q == dmx_pkg::Q4 &&
		kind == dmx_pkg::K_LOAD_BANK
		|=> bankPointer == {4'h0, $past(lowByte[3:0])})
		else $error("bank pointer load wrong");

	a_acc_load: assert property (                                   // [RQ12]
		r.st == dmx_pkg::ST_EXEC && q == dmx_pkg::Q4 &&
		kind == dmx_pkg::K_LOAD_ACC
		|=> r.acc == $past(lowByte) && $stable(r.neg) && $stable(r.zero))
		else $error("accumulator literal load wrong");

	a_cycle_len: assert property (                                  // [RQ13]
		r.st == dmx_pkg::ST_EXEC && q == dmx_pkg::Q1
		|-> ##4 r.st == dmx_pkg::ST_IDLE || r.st == dmx_pkg::ST_WAIT2)
		else $error("instruction cycle not four clocks");

	a_no_read2: assert property (                                   // [RQ14]
		r.st == dmx_pkg::ST_EXEC2 |-> ##1 !r.memRd)
		else $error("data read during second file move cycle");

endmodule

/* File: verilog/dmx_qphase.sv */
// quarter-phase counter of the instruction cycle
`timescale 1ns/1ns
module dmx_qphase
(
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       run,
	output logic [1:0]      phase
);

	typedef struct packed
	{
		logic [1:0] q;
	} dmx_qphase_s;

	dmx_qphase_s r;
	dmx_qphase_s n;

	// ----------------------------------------------------------------
	// counts Q1..Q4 while running, parks on Q1 otherwise
	// ----------------------------------------------------------------
	always_comb
	begin
		n = r;
		if (run)
			n.q = r.q + 2'h1;
		else
			n.q = dmx_pkg::Q1;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			r <= '0;
		else
			r <= n;
	end

	assign phase = r.q;

endmodule
